/* hw/pmsc_top.sv */
// Pattern-match bit-slice selection, detection and product-term logic.
// Assumes an AXI4-Lite master on ref_clk_i; pin inputs are asynchronous.
// Summary of operation
// - Slice 6 three-bit source field picks one of eight inputs, resets zero.
// - Slice 7 three-bit source field uses same coding, resets zero.
// - Slices 0-5 source fields packed contiguously below slice 6 field.
// - Each slice selects one of eight detection conditions from configuration.
// - Low seven configuration bits mark product-term endpoints.
// - Sticky detector holds high after qualifying edge until cleared.
// - Non-sticky detector pulses high exactly one cycle per edge.
// - Any write to configuration or source register clears edge history.
// - Both control enable bits zero clears edge history.
// - Endpoint slice raises its interrupt while its term matches.
// - Slice after an endpoint starts a new independent ORed term.
// - Endpoint bit 0 makes slice 0 end a term, raising interrupt 0.
// - Endpoint bit 1 makes slice 1 end a term, raising interrupt 1.
// - Endpoint bit 2 makes slice 2 end a term, raising interrupt 2.
// - Configuration bit 3 decides whether slice 3 ends a term.
// - Endpoint bits 4 to 6 behave likewise for slices 4-6.
`timescale 1ns/1ps
`include "pmsc_consts.svh"
`default_nettype none
module pmsc_top #(
   parameter int NSLICE = 8
) (
   input  wire logic            ref_clk_i,
   input  wire logic            rst_i,
   input  wire logic [7:0]      pin_irq_i,
   output logic      [7:0]      pin_int_o,
   output logic                 pattern_match_o,
   output logic                 irq_o,
   input  wire logic [31:0]     s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire pmsc_pkg::pmsc_word_t s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output pmsc_pkg::pmsc_resp_t s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [31:0]     s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output pmsc_pkg::pmsc_word_t s_axi_rdata,
   output pmsc_pkg::pmsc_resp_t s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready
);
   import pmsc_pkg::*;

   // Bus state
   logic [31:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        aw_have_r;
   logic        w_have_r;
   logic        awready_r;
   logic        wready_r;
   logic        bvalid_r;
   pmsc_resp_t  bresp_r;
   logic        arready_r;
   logic        rvalid_r;
   pmsc_word_t  rdata_r;
   pmsc_resp_t  rresp_r;

   // Registers
   pmsc_word_t  src_r;
   pmsc_word_t  cfg_r;
   logic [1:0]  ctrl_r;
   logic [7:0]  stat_r;
   logic [7:0]  mask_r;

   // Detection
   logic [7:0]  sync1_r;
   logic [7:0]  sync2_r;
   logic [7:0]  prev_r;
   logic [NSLICE-1:0] st_r;
   logic [NSLICE-1:0] ns_r;
   logic [NSLICE-1:0] det;
   logic [NSLICE-1:0] run_and;
   logic [NSLICE-1:0] endpt;
   logic [NSLICE-1:0] match;
   logic [7:0]  pin_int_r;
   logic        pmatch_r;
   logic        irq_r;

   assign s_axi_awready   = awready_r;
   assign s_axi_wready    = wready_r;
   assign s_axi_bvalid    = bvalid_r;
   assign s_axi_bresp     = bresp_r;
   assign s_axi_arready   = arready_r;
   assign s_axi_rvalid    = rvalid_r;
   assign s_axi_rdata     = rdata_r;
   assign s_axi_rresp     = rresp_r;
   assign pin_int_o       = pin_int_r;
   assign pattern_match_o = pmatch_r;
   assign irq_o           = irq_r;

   // Write path: address and data are taken in either order
   wire aw_hs    = s_axi_awvalid & awready_r;
   wire w_hs     = s_axi_wvalid & wready_r;
   wire b_hs     = bvalid_r & s_axi_bready;
   wire do_write = aw_have_r & w_have_r & ~bvalid_r;
   wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                        {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   wire [31:0] wmerged_src  = (src_r & ~wmask) | (wdata_r & wmask);
   wire [31:0] wmerged_cfg  = (cfg_r & ~wmask) | (wdata_r & wmask);
   wire wr_src   = do_write & (awaddr_r == `PMSC_ADDR_SRC);
   wire wr_cfg   = do_write & (awaddr_r == `PMSC_ADDR_CFG);
   wire wr_ctrl  = do_write & (awaddr_r == `PMSC_ADDR_CTRL) & wstrb_r[0];
   wire wr_stat  = do_write & (awaddr_r == `PMSC_ADDR_IRQ_STAT) & wstrb_r[0];
   wire wr_mask  = do_write & (awaddr_r == `PMSC_ADDR_IRQ_MASK) & wstrb_r[0];
   wire wr_hit   = (awaddr_r == `PMSC_ADDR_SRC) | (awaddr_r == `PMSC_ADDR_CFG) |
                   (awaddr_r == `PMSC_ADDR_CTRL) | (awaddr_r == `PMSC_ADDR_IRQ_STAT) |
                   (awaddr_r == `PMSC_ADDR_IRQ_MASK);

   // Read path
   wire ar_hs = s_axi_arvalid & arready_r;
   wire r_hs  = rvalid_r & s_axi_rready;
   wire rd_src  = s_axi_araddr == `PMSC_ADDR_SRC;
   wire rd_cfg  = s_axi_araddr == `PMSC_ADDR_CFG;
   wire rd_ctrl = s_axi_araddr == `PMSC_ADDR_CTRL;
   wire rd_stat = s_axi_araddr == `PMSC_ADDR_IRQ_STAT;
   wire rd_mask = s_axi_araddr == `PMSC_ADDR_IRQ_MASK;
   wire rd_hit  = rd_src | rd_cfg | rd_ctrl | rd_stat | rd_mask;
   wire [31:0] rd_word = rd_src  ? src_r :
                         rd_cfg  ? cfg_r :
                         rd_ctrl ? {30'h0, ctrl_r} :
                         rd_stat ? {24'h0, stat_r} :
                         rd_mask ? {24'h0, mask_r} : 32'h0000_0000;

   // Clearing all edge history on config writes or when disabled
   wire engine_off = ~ctrl_r[`PMSC_CTRL_SEL_BIT] & ~ctrl_r[`PMSC_CTRL_RXEV_BIT];
   wire clr_hist   = wr_src | wr_cfg | engine_off;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= 32'h0000_0000;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `PMSC_RESP_OKAY;
      end else begin
         if (aw_hs) begin
            awaddr_r  <= s_axi_awaddr;
            aw_have_r <= 1'b1;
            awready_r <= 1'b0;
         end
         if (w_hs) begin
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
            w_have_r <= 1'b1;
            wready_r <= 1'b0;
         end
         if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? `PMSC_RESP_OKAY : `PMSC_RESP_SLVERR;
         end
         if (b_hs) begin
            bvalid_r  <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= `PMSC_RESP_OKAY;
      end else if (ar_hs) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_word;
         rresp_r   <= rd_hit ? `PMSC_RESP_OKAY : `PMSC_RESP_SLVERR;
      end else if (r_hs) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   // Source fields sit at bits 31:8, three bits per slice
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         src_r  <= `PMSC_SRC_RST;
         cfg_r  <= `PMSC_CFG_RST;
         ctrl_r <= 2'h0;
         mask_r <= 8'h00;
      end else begin
         if (wr_src)
            src_r <= {wmerged_src[31:8], 8'h00};
         if (wr_cfg)
            cfg_r <= {wmerged_cfg[31:8], 1'b0, wmerged_cfg[6:0]};
         if (wr_ctrl)
            ctrl_r <= wdata_r[1:0];
         if (wr_mask)
            mask_r <= wdata_r[7:0];
      end
   end

   // Pins are asynchronous; two flops before any use
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
         prev_r  <= 8'h00;
      end else begin
         sync1_r <= pin_irq_i;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NSLICE; gi++) begin : g_slice
         wire [2:0] sel  = src_r[`PMSC_SRC_LSB + `PMSC_SRC_W*gi +: `PMSC_SRC_W];
         wire       cur  = sync2_r[sel];
         wire       old  = prev_r[sel];
         wire       rise = cur & ~old;
         wire       fall = ~cur & old;
         wire [2:0] mraw = cfg_r[`PMSC_CFG_MODE_LSB + `PMSC_CFG_MODE_W*gi +: `PMSC_CFG_MODE_W];
         pmsc_cond_e mode;
         logic       st_set;
         assign mode = pmsc_cond_e'(mraw);
         always_comb begin
            case (mode)
               PMSC_COND_ST_RISE: st_set = rise;
               PMSC_COND_ST_FALL: st_set = fall;
               PMSC_COND_ST_ANY:  st_set = rise | fall;
               default:           st_set = 1'b0;
            endcase
         end
         // History clear wins: an edge judged under the old setup is void
         always_ff @(posedge ref_clk_i) begin
            if (rst_i | clr_hist) begin
               st_r[gi] <= 1'b0;
               ns_r[gi] <= 1'b0;
            end else begin
               st_r[gi] <= st_r[gi] | st_set;
               ns_r[gi] <= (mode == PMSC_COND_NS_ANY) & (rise | fall);
            end
         end
         always_comb begin
            case (mode)
               PMSC_COND_HIGH:    det[gi] = 1'b1;
               PMSC_COND_ST_RISE,
               PMSC_COND_ST_FALL,
               PMSC_COND_ST_ANY:  det[gi] = st_r[gi];
               PMSC_COND_LVL_HI:  det[gi] = cur;
               PMSC_COND_LVL_LO:  det[gi] = ~cur;
               PMSC_COND_LOW:     det[gi] = 1'b0;
               PMSC_COND_NS_ANY:  det[gi] = ns_r[gi];
               default:           det[gi] = 1'b0;
            endcase
         end
         if (gi == NSLICE-1) begin : g_last
            assign endpt[gi] = 1'b1;
         end else begin : g_ep
            assign endpt[gi] = cfg_r[gi];
         end
         if (gi == 0) begin : g_first
            assign run_and[gi] = det[gi];
         end else begin : g_next
            assign run_and[gi] = det[gi] & (endpt[gi-1] | run_and[gi-1]);
         end
         assign match[gi] = run_and[gi] & endpt[gi];
      end
   endgenerate

   // Interrupt status: set wins over write-one-to-clear
   wire [7:0] stat_clr = wr_stat ? wdata_r[7:0] : 8'h00;
   wire       active   = ~engine_off;
   wire [7:0] events   = active ? match : 8'h00;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_int_r <= 8'h00;
         pmatch_r  <= 1'b0;
         stat_r    <= 8'h00;
         irq_r     <= 1'b0;
      end else begin
         pin_int_r <= events;
         pmatch_r  <= |events;
         stat_r    <= (stat_r & ~stat_clr) | events;
         irq_r     <= |(stat_r & mask_r);
      end
   end

   property p_src_reset;
      @(posedge ref_clk_i) $fell(rst_i) |-> (src_r[31:26] == 6'h00) && (src_r[25:8] == 18'h0);
   endproperty
   a_src_reset: assert property (p_src_reset) else $error("source fields not zero after reset");

   property p_sticky_hold;
      @(posedge ref_clk_i) disable iff (rst_i)
         st_r[0] && !clr_hist |=> st_r[0];
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) else $error("sticky detector dropped");

   property p_ns_cause;
      @(posedge ref_clk_i) disable iff (rst_i)
         ns_r[7] |-> $past(g_slice[7].rise | g_slice[7].fall) && !$past(clr_hist);
   endproperty
   a_ns_cause: assert property (p_ns_cause) else $error("non-sticky pulse without edge");

   property p_cfg_clear;
      @(posedge ref_clk_i) disable iff (rst_i)
         wr_cfg || wr_src |=> (st_r == '0) && (ns_r == '0);
   endproperty
   a_cfg_clear: assert property (p_cfg_clear) else $error("history kept after write");

   property p_off_clear;
      @(posedge ref_clk_i) disable iff (rst_i)
         engine_off |=> (st_r == '0) && (pin_int_r == 8'h00);
   endproperty
   a_off_clear: assert property (p_off_clear) else $error("history kept while disabled");

   property p_irq_term;
      @(posedge ref_clk_i) disable iff (rst_i)
         active && cfg_r[0] && det[0] |=> pin_int_r[0];
   endproperty
   a_irq_term: assert property (p_irq_term) else $error("endpoint 0 did not raise");

   property p_and_term;
      @(posedge ref_clk_i) disable iff (rst_i)
         pin_int_r[2] && $past(cfg_r[1:0] == 2'b00) |-> $past(det[0] & det[1] & det[2]);
   endproperty
   a_and_term: assert property (p_and_term) else $error("term 2 not an AND of slices");

   property p_last_end;
      @(posedge ref_clk_i) disable iff (rst_i)
         active && det[7] && cfg_r[6] |=> pin_int_r[7];
   endproperty
   a_last_end: assert property (p_last_end) else $error("slice 7 not a term end");

   property p_stat_set;
      @(posedge ref_clk_i) disable iff (rst_i)
         events[3] |=> stat_r[3] ##1 (irq_r || !$past(mask_r[3]));
   endproperty
   a_stat_set: assert property (p_stat_set) else $error("status lost on event");

endmodule : pmsc_top
`default_nettype wire

/* hw/pmsc_consts.svh */
// Offsets, field positions, reset values for the slice configuration block.
// Assumes a 32-bit AXI4-Lite byte address; registers are aligned words.
`ifndef PMSC_CONSTS_SVH
`define PMSC_CONSTS_SVH
`define PMSC_ADDR_SRC        32'ha000_402c
`define PMSC_ADDR_CFG        32'ha000_4030
`define PMSC_ADDR_CTRL       32'ha000_4034
`define PMSC_ADDR_IRQ_STAT   32'ha000_4038
`define PMSC_ADDR_IRQ_MASK   32'ha000_403c
`define PMSC_SRC_LSB         8
`define PMSC_SRC_W           3
`define PMSC_CFG_EP_W        7
`define PMSC_CFG_MODE_LSB    8
`define PMSC_CFG_MODE_W      3
`define PMSC_CTRL_SEL_BIT    0
`define PMSC_CTRL_RXEV_BIT   1
`define PMSC_SRC_RST         32'h0000_0000
`define PMSC_CFG_RST         32'h0000_0000
`define PMSC_CTRL_RST        32'h0000_0000
`define PMSC_RESP_OKAY       2'h0
`define PMSC_RESP_SLVERR     2'h2
`endif

/* hw/pmsc_pkg.sv */
// Types shared by the slice configuration block.
// Assumes the constants header is compiled alongside.
package pmsc_pkg;
   typedef enum logic [2:0] {
      PMSC_COND_HIGH   = 3'b000,
      PMSC_COND_ST_RISE = 3'b001,
      PMSC_COND_ST_FALL = 3'b010,
      PMSC_COND_ST_ANY  = 3'b011,
      PMSC_COND_LVL_HI  = 3'b100,
      PMSC_COND_LVL_LO  = 3'b101,
      PMSC_COND_LOW     = 3'b110,
      PMSC_COND_NS_ANY  = 3'b111
   } pmsc_cond_e;
   typedef logic [31:0] pmsc_word_t;
   typedef logic [1:0]  pmsc_resp_t;
endpackage : pmsc_pkg

/* hw/_unused_placeholder_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verification/pattern_match_slice_config_test.sv */
// Self-checking bench for the pattern-match slice block, registers over AXI4-Lite.
// Assumes pmsc_pkg and pmsc_consts.svh are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`include "pmsc_consts.svh"
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module pattern_match_slice_config_test;
   import pmsc_pkg::*;
   logic       ref_clk_i = 1'b0;
   logic       rst_i     = 1'b1;
   logic [7:0] pin_irq_i = 8'h00;
   logic [7:0] pin_int_o;
   logic       pattern_match_o, irq_o;
   logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_araddr = 32'h0000_0000;
   pmsc_word_t s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic       s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic       s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   pmsc_resp_t s_axi_bresp, s_axi_rresp;
   int         err_count = 0;
   int         comparisons = 0;
   logic [31:0] rd;
   logic [1:0]  rsp;

   pmsc_top #(.NSLICE(8)) DUT (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_irq_i(pin_irq_i), .pin_int_o(pin_int_o),
      .pattern_match_o(pattern_match_o), .irq_o(irq_o),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   always #5 ref_clk_i = ~ref_clk_i;

   // Waits for the answer as long as it takes; only the watchdog ends a hang
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_awvalid && s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         r = s_axi_bresp;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      // Idle edge so a following call never drives bready twice in one step
      @(posedge ref_clk_i);
   endtask : axi_write

   task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         if (s_axi_arvalid && s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         d = s_axi_rdata;
         r = s_axi_rresp;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      // Idle edge so a following call never drives rready twice in one step
      @(posedge ref_clk_i);
   endtask : axi_read

   // Two sync flops plus detector and output register, with margin
   task automatic pins(input logic [7:0] v);
      pin_irq_i <= v;
      repeat (6) @(posedge ref_clk_i);
   endtask : pins

   // Counts cycles the non-sticky slice 7 is high after a pin 0 change
   task automatic pulse_count(input logic v, output int c);
      c = 0;
      pin_irq_i <= {7'h00, v};
      repeat (10) begin
         @(posedge ref_clk_i);
         if (pin_int_o[7] === 1'b1) c++;
      end
   endtask : pulse_count

   function automatic logic [31:0] srcval(input int rot);
      logic [31:0] v;
      v = 32'h0000_0000;
      for (int k = 0; k < 8; k++) v |= 32'((k + rot) % 8) << (8 + 3 * k);
      return v;
   endfunction : srcval

   task automatic t_reset();
      axi_read(`PMSC_ADDR_SRC, rd, rsp); `CHK(rd, `PMSC_SRC_RST)
      axi_read(`PMSC_ADDR_CFG, rd, rsp); `CHK(rd, `PMSC_CFG_RST)
      axi_read(`PMSC_ADDR_CTRL, rd, rsp); `CHK(rd, `PMSC_CTRL_RST)
      `CHK(pin_int_o, 8'h00)
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs();
      axi_write(`PMSC_ADDR_SRC, 32'hffff_ffff, rsp); `CHK(rsp, `PMSC_RESP_OKAY)
      axi_read(`PMSC_ADDR_SRC, rd, rsp); `CHK(rd, 32'hffff_ff00)
      axi_write(`PMSC_ADDR_CFG, 32'hffff_ffff, rsp);
      axi_read(`PMSC_ADDR_CFG, rd, rsp); `CHK(rd, 32'hffff_ff7f)
      axi_write(32'ha000_4040, 32'h1234_5678, rsp); `CHK(rsp, `PMSC_RESP_SLVERR)
      axi_read(32'ha000_4040, rd, rsp); `CHK({rsp, rd}, {`PMSC_RESP_SLVERR, 32'h0000_0000})
      $display("test registers done");
   endtask : t_regs

   // Every slice level-high and its own term; each rotation uses all eight codes
   task automatic t_route();
      axi_write(`PMSC_ADDR_CFG, 32'h9249_247f, rsp);
      axi_write(`PMSC_ADDR_CTRL, 32'h0000_0001, rsp);
      for (int rot = 0; rot < 8; rot++) begin
         axi_write(`PMSC_ADDR_SRC, srcval(rot), rsp);
         pins(8'h01);
         `CHK(pin_int_o, 8'(1 << ((8 - rot) % 8)))
         `CHK(pattern_match_o, 1'b1)
         pins(8'h00);
      end
      $display("test routing done");
   endtask : t_route

   // Endpoint only at slice 2: terms are slices 0..2 and 3..7
   task automatic t_terms();
      axi_write(`PMSC_ADDR_SRC, srcval(0), rsp);
      axi_write(`PMSC_ADDR_CFG, 32'h9249_2404, rsp);
      pins(8'h07); `CHK(pin_int_o, 8'h04)
      pins(8'h03); `CHK(pin_int_o, 8'h00)
      pins(8'hf8); `CHK(pin_int_o, 8'h80)
      pins(8'hff); `CHK(pin_int_o, 8'h84)
      pins(8'h00);
      $display("test product terms done");
   endtask : t_terms

   // Slice k uses condition k, all on pin 0, each slice its own term
   task automatic t_modes();
      int c;
      axi_write(`PMSC_ADDR_SRC, 32'h0000_0000, rsp);
      axi_write(`PMSC_ADDR_CFG, 32'hfac6_887f, rsp);
      pins(8'h00); `CHK(pin_int_o, 8'h21)
      pulse_count(1'b1, c); `CHK(c, 1)
      `CHK(pin_int_o, 8'h1b)
      pulse_count(1'b0, c); `CHK(c, 1)
      `CHK(pin_int_o, 8'h2f)
      axi_write(`PMSC_ADDR_CFG, 32'hfac6_887f, rsp);
      pins(8'h00); `CHK(pin_int_o, 8'h21)
      pins(8'h01); `CHK(pin_int_o, 8'h1b)
      axi_write(`PMSC_ADDR_SRC, 32'h0000_0000, rsp);
      pins(8'h01); `CHK(pin_int_o, 8'h11)
      pins(8'h00); `CHK(pin_int_o, 8'h2d)
      axi_write(`PMSC_ADDR_CTRL, 32'h0000_0000, rsp);
      pins(8'h00); `CHK(pin_int_o, 8'h00)
      axi_write(`PMSC_ADDR_CTRL, 32'h0000_0002, rsp);
      pins(8'h00); `CHK(pin_int_o, 8'h21)
      $display("test conditions done");
   endtask : t_modes

   task automatic t_irq();
      axi_write(`PMSC_ADDR_IRQ_MASK, 32'h0000_0000, rsp);
      pins(8'h00); `CHK(irq_o, 1'b0)
      axi_read(`PMSC_ADDR_IRQ_STAT, rd, rsp); `CHK(rd & 32'h21, 32'h0000_0021)
      axi_write(`PMSC_ADDR_IRQ_MASK, 32'h0000_0020, rsp);
      pins(8'h00); `CHK(irq_o, 1'b1)
      axi_write(`PMSC_ADDR_CTRL, 32'h0000_0000, rsp);
      pins(8'h00);
      axi_write(`PMSC_ADDR_IRQ_STAT, 32'h0000_00ff, rsp);
      axi_read(`PMSC_ADDR_IRQ_STAT, rd, rsp); `CHK(rd, 32'h0000_0000)
      pins(8'h00); `CHK(irq_o, 1'b0)
      $display("test interrupt done");
   endtask : t_irq

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   // Tests need a few hundred cycles; 20000 cycles means a hang
   initial begin
      #200us;
      err_count++;
      summarize();
   end

   initial begin
      repeat (4) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_reset();
      t_regs();
      t_route();
      t_terms();
      t_modes();
      t_irq();
      summarize();
   end
endmodule : pattern_match_slice_config_test
`default_nettype wire
